// >>> verilog/adc_deep_powerdown_control.sv
`timescale 1ns/10ps
`include "adc_pd_params.svh"
module adc_deep_powerdown_control
  import adc_pd_pkg::*;
#(
  parameter int PWRUP_CYCLES = `PWRUP_WAIT_CYC
)
(
  input  wire logic       clk,
  input  wire logic       resetn,
  input  wire logic       regWrite,
  input  wire logic [7:0] regAddr,
  input  wire logic [7:0] regData,
  input  wire logic       convertStartSelect,
  input  wire logic       convBusy,
  output logic            readyValidOutput,
  output logic            analogEnable,
  output logic            deepSleepState,
  output logic            powerUpDone,
  output logic            powerDownBit,
  output logic            controlUnlocked
);
  // ==========================================================
  // behaviour notes
  // ==========================================================
  // the block is a small sequencer between the write port and the analog
  // power switch. it never blocks a write: the interface stays alive in
  // every state, so the host can always clear the power-down bit again.
  //
  // entry needs three things in order: a key write, a bit write of one,
  // and a rising level on the conversion-start pin. the pin goes through
  // two flops first, so entry lands three clocks after the pin rises.
  // that latency is the price of a clean synchroniser; the host can
  // see it, since ready follows convBusy while armed and is forced high only from sleep on.
  //
  // exit needs only the key write and a bit write of zero. the sequencer
  // then spends PWRUP_CYCLES clocks in the waking state. the host does not
  // watch that count; it keeps its own wait before the next conversion.
  // the count drives the power-up flag, the analog switch and the forced-high ready.
  //
  // the unlock is single use on purpose: one key opens one bit write, so
  // a stray write to the control address cannot flip the bit later on.
  //
  // limitation: a conversion-start rise while sleeping or waking is
  // ignored here; the converter core must not start a conversion then.

  // reset value of the control register, bit picked out below
  localparam logic [7:0] CTRL_RESET = `PD_CTRL_RESET;
  // ==========================================================
  // pin capture
  // ==========================================================
  logic convSync;
  logic convPrev_q;
  wire  convRise = convSync & ~convPrev_q;

  pin_sync u_conv_sync
  (
    .clk    (clk),
    .resetn (resetn),
    .pinIn  (convertStartSelect),
    .pinOut (convSync)
  );

  always_ff @(posedge clk or negedge resetn)
  begin
    if (!resetn)
      convPrev_q <= 1'b0;
    else
      convPrev_q <= convSync;
  end

  // ==========================================================
  // register write decode
  // ==========================================================
  wire ctrlHit  = regWrite && (regAddr == `PD_CTRL_ADDR);
  wire keyWrite = ctrlHit && (regData == `PD_CTRL_KEY);
  wire bitWrite = ctrlHit && !keyWrite && controlUnlocked;
  wire newBit   = regData[`PD_BIT_POS];

  // the unlock lasts for one following control-address write; a key write re-arms it
  always_ff @(posedge clk or negedge resetn)
  begin
    if (!resetn)
      controlUnlocked <= 1'b0;
    else if (keyWrite)
      controlUnlocked <= 1'b1;
    else if (ctrlHit)
      controlUnlocked <= 1'b0;
  end

  // power-down bit held in the retained register, untouched by sleep
  always_ff @(posedge clk or negedge resetn)
  begin
    if (!resetn)
      powerDownBit <= CTRL_RESET[`PD_BIT_POS];
    else if (bitWrite)
      powerDownBit <= newBit;
  end

  // ==========================================================
  // sleep sequencer
  // ==========================================================
  localparam int CW = $clog2(PWRUP_CYCLES + 1);
  pd_state_t state_q;
  pd_state_t state_d;
  logic [CW-1:0] wait_q;
  wire waitDone = (wait_q == CW'(PWRUP_CYCLES - 1));

  // clear while armed simply cancels the pending entry
  always_comb
  begin
    state_d = state_q;
    case (state_q)
      ST_ACTIVE: if (powerDownBit) state_d = ST_ARMED;
      ST_ARMED:
        if (!powerDownBit)
          state_d = ST_ACTIVE;
        else if (convRise)
          state_d = ST_SLEEP;
      ST_SLEEP:  if (!powerDownBit) state_d = ST_WAKING;
      ST_WAKING:
        if (powerDownBit)
          state_d = ST_SLEEP;
        else if (waitDone)
          state_d = ST_ACTIVE;
      default:   state_d = ST_ACTIVE;
    endcase
  end

  always_ff @(posedge clk or negedge resetn)
  begin
    if (!resetn)
      state_q <= ST_ACTIVE;
    else
      state_q <= state_d;
  end

  // power-up wait counter, ends the waking state; host times its own wait
  always_ff @(posedge clk or negedge resetn)
  begin
    if (!resetn)
      wait_q <= '0;
    else if (state_q == ST_WAKING && !waitDone)
      wait_q <= wait_q + CW'(1);
    else
      wait_q <= '0;
  end

  // ==========================================================
  // registered outputs
  // ==========================================================
  // state decode, shared by the output flops
  // kept as functions so every output reads the same decode
  function automatic logic isSleep(input pd_state_t s);
    return (s == ST_SLEEP);
  endfunction

  function automatic logic isWaking(input pd_state_t s);
    return (s == ST_WAKING);
  endfunction

  // analog stays on while armed: entry waits for the pin edge
  function automatic logic isPowered(input pd_state_t s);
    return (s == ST_ACTIVE) || (s == ST_ARMED);
  endfunction

  // decode the next state so outputs change with the state flop
  wire sleepNext = isSleep(state_d);
  wire wakeNext  = isWaking(state_d);
  wire analogOn  = isPowered(state_d);

  always_ff @(posedge clk or negedge resetn)
  begin
    if (!resetn)
    begin
      readyValidOutput <= 1'b1;
      analogEnable     <= 1'b1;
      deepSleepState   <= 1'b0;
      powerUpDone      <= 1'b1;
    end
    else
    begin
      // high in sleep and on wake; else follows converter busy
      readyValidOutput <= sleepNext || wakeNext || !convBusy;
      analogEnable     <= analogOn && !sleepNext;
      deepSleepState   <= sleepNext;
      powerUpDone      <= analogOn;
    end
  end
endmodule // adc_deep_powerdown_control

// >>> verilog/adc_pd_params.svh
`ifndef ADC_PD_PARAMS_SVH
`define ADC_PD_PARAMS_SVH
// register write port constants
`define PD_CTRL_ADDR      8'h05
`define PD_CTRL_KEY       8'h69
`define PD_BIT_POS        0
`define PD_CTRL_RESET     8'h00
// power-up wait time in ns and derived cycles at 100 MHz
`define PWRUP_WAIT_NS     1000
`define CLK_PERIOD_NS     10
`define PWRUP_WAIT_CYC    ((`PWRUP_WAIT_NS + `CLK_PERIOD_NS - 1) / `CLK_PERIOD_NS)
`endif

// >>> verilog/adc_pd_pkg.sv
package adc_pd_pkg;
  typedef enum logic [3:0] {
    ST_ACTIVE   = 4'b0001,
    ST_ARMED    = 4'b0010,
    ST_SLEEP    = 4'b0100,
    ST_WAKING   = 4'b1000
  } pd_state_t;
endpackage

// >>> verilog/pin_sync.sv
`timescale 1ns/10ps
// two-flop synchroniser for a pin level
module pin_sync
(
  input  wire logic clk,
  input  wire logic resetn,
  input  wire logic pinIn,
  output logic      pinOut
);
  logic stage1_q;

  // first flop feeds only the second
  always_ff @(posedge clk or negedge resetn)
  begin
    if (!resetn)
    begin
      stage1_q <= 1'b0;
      pinOut   <= 1'b0;
    end
    else
    begin
      stage1_q <= pinIn;
      pinOut   <= stage1_q;
    end
  end
endmodule // pin_sync

// >>> dv/adc_pd_monitor.sv
`timescale 1ns/10ps
// ====
// deep sleep checker
module adc_pd_monitor
(
  input wire logic clk,
  input wire logic resetn,
  input wire logic convertStartSelect,
  input wire logic readyValidOutput,
  input wire logic analogEnable,
  input wire logic deepSleepState,
  input wire logic powerDownBit
);
  default clocking @(posedge clk); endclocking
  default disable iff (!resetn);
  // asleep: ready high, analog off
  property p_rdy; deepSleepState |-> readyValidOutput; endproperty
  a_rdy: assert property (p_rdy) else $error("ready low");
  property p_ana; deepSleepState |-> !analogEnable; endproperty
  a_ana: assert property (p_ana) else $error("analog on");
  // window covers the pin synchroniser
  property p_ent;
    $rose(convertStartSelect) && powerDownBit |-> ##[2:5] deepSleepState;
  endproperty
  a_ent: assert property (p_ent) else $error("no entry");
  property p_ext;
    $fell(powerDownBit) && deepSleepState |-> ##[0:2] readyValidOutput && !deepSleepState;
  endproperty
  a_ext: assert property (p_ext) else $error("no exit");
endmodule // adc_pd_monitor
bind adc_deep_powerdown_control adc_pd_monitor mon_u (.clk, .resetn, .convertStartSelect,
  .readyValidOutput, .analogEnable, .deepSleepState, .powerDownBit);

// >>> dv/host_model.sv
`timescale 1ns/10ps
// ====
// host: writes and pin edges
module host_model
(
  input  wire logic       clk,
  output logic            regWrite,
  output logic [7:0]      regAddr,
  output logic [7:0]      regData,
  output logic            convertStartSelect
);
  initial {regWrite, regAddr, regData, convertStartSelect} = '0;
  // idle lines show the inverse, never a stale value
  task automatic wr(input logic [7:0] a, input logic [7:0] d);
    @(negedge clk);
    {regWrite, regAddr, regData} = {1'b1, a, d};
    @(negedge clk);
    {regWrite, regAddr, regData} = {1'b0, ~a, ~d};
  endtask
  // rising edge starts entry or a conversion
  task automatic conv(input int hold);
    @(negedge clk);
    convertStartSelect = 1'b1;
    repeat (hold) @(negedge clk);
    convertStartSelect = 1'b0;
  endtask
endmodule // host_model

// >>> dv/tb.sv
`timescale 1ns/10ps
// ====
// deep sleep bench
module tb;
  localparam int PWRUP_CYCLES = 4;
  logic        clk = 1'b0, resetn = 1'b0, convBusy = 1'b0, expPd = 1'b0, expUnl = 1'b0;
  logic        regWrite, convertStartSelect, readyValidOutput, analogEnable;
  logic        deepSleepState, powerUpDone, powerDownBit, controlUnlocked;
  logic [7:0]  regAddr, regData;
  logic [31:0] rnd = 32'h7c5ed9da;
  int          errorCnt = 0, nChecks = 0;
  host_model host_u (.clk, .regWrite, .regAddr, .regData, .convertStartSelect);
  adc_deep_powerdown_control #(.PWRUP_CYCLES(PWRUP_CYCLES)) dut_u (.clk, .resetn,
    .regWrite, .regAddr, .regData, .convertStartSelect, .convBusy, .readyValidOutput,
    .analogEnable, .deepSleepState, .powerUpDone, .powerDownBit, .controlUnlocked);
  initial forever #5 clk = ~clk;
  // a hang counts as a mismatch
  initial
  begin
    #20000 errorCnt++;
    results();
  end
  function automatic logic [31:0] xs(input logic [31:0] s);
    s ^= s << 13;
    s ^= s >> 17;
    return s ^ (s << 5);
  endfunction
  task automatic chk(input logic v, input logic e);
    nChecks++;
    if (v !== e)
    begin
      errorCnt++;
      $display("unexpected %0t value mismatch", $time);
    end
  endtask
  task automatic results();
    if (errorCnt == 0 && nChecks > 0)
      $display("ALL CHECKS OK");
    else
      $display("CHECKS NOT OK");
    $finish;
  endtask
  // write, then the key-and-bit model predicts the register
  task automatic wrm(input logic [7:0] a, input logic [7:0] d);
    host_u.wr(a, d);
    if (a == 8'h05 && d != 8'h69 && expUnl)
      {expPd, expUnl} = {d[0], 1'b0};
    else if (a == 8'h05 && d == 8'h69)
      expUnl = 1'b1;
    chk(powerDownBit, expPd);
    chk(controlUnlocked, expUnl);
  endtask
  initial
  begin
    repeat (10) @(negedge clk);
    resetn = 1'b1;
    wrm(8'h05, {rnd[7:2], 2'b11});
    wrm(8'h06, 8'h69);
    wrm(8'h05, 8'h69);
    wrm(8'h05, 8'h01);
    chk(deepSleepState, 1'b0);
    convBusy = 1'b1;
    host_u.conv(6);
    chk(deepSleepState, 1'b1);
    chk(analogEnable, 1'b0);
    chk(readyValidOutput, 1'b1);
    wrm(8'h05, 8'h00);
    host_u.conv(2);
    chk(deepSleepState, 1'b1);
    wrm(8'h05, 8'h69);
    wrm(8'h05, 8'h00);
    @(negedge clk);
    chk(readyValidOutput, 1'b1);
    chk(deepSleepState, 1'b0);
    repeat (PWRUP_CYCLES + 2) @(negedge clk);
    chk(analogEnable, 1'b1);
    chk(powerUpDone, 1'b1);
    // random busy levels while converting awake
    repeat (8)
    begin
      rnd = xs(rnd);
      convBusy = rnd[0];
      host_u.conv(2);
      chk(readyValidOutput, !convBusy);
      chk(deepSleepState, 1'b0);
    end
    results();
  end
endmodule // tb
